//--- trig_enc_params.svh
/*
 * Offsets, field positions, reset values and codes of the trigger and encoder unit.
 * Assumes inclusion by the package and the testbench; definitions only.
 */
`ifndef TRIG_ENC_PARAMS_SVH
`define TRIG_ENC_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_PER_TRIG 8'h04
`define OFS_WIN_LO 8'h08
`define OFS_WIN_HI 8'h0c
`define OFS_SPACING 8'h10
`define OFS_DEPTH 8'h14
`define OFS_MARKER 8'h18
`define OFS_PRESET_A 8'h1c
`define OFS_PRESET_B 8'h20
`define OFS_PRESET_C 8'h24
`define OFS_WRAP_A 8'h28
`define OFS_WRAP_B 8'h2c
`define OFS_CMD 8'h30
`define OFS_STATUS 8'h34
`define OFS_CNT_A 8'h38
`define OFS_CNT_B 8'h3c
`define OFS_CNT_C 8'h40
`define OFS_REMAIN 8'h44

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_ORIGIN_LSB 0
`define CTRL_TARGET_BIT 3
`define CTRL_KIND_BIT 4
`define CTRL_POL_BIT 5
`define CTRL_HTL_BIT 6
`define CTRL_THIRD_BIT 7

// ----------------------------------------
// command register bits (write one to act)
// ----------------------------------------
`define CMD_TRIGGER_BIT 0
`define CMD_LOAD_LSB 1
`define CMD_MCLR_LSB 4
`define CMD_CLR_TS_BIT 6
`define CMD_CLR_MC_BIT 7

// ----------------------------------------
// values and sizes
// ----------------------------------------
`define PER_TRIG_NONE 32'h0000_0000
`define PER_TRIG_INFINITE 32'hffff_ffff
`define PER_TRIG_RESET 32'hffff_ffff
`define WRAP_RESET 32'hffff_ffff
`define HSIZE_WORD 3'h2
`define SYNC_W 11
`define SYNC_DIFF 0
`define SYNC_SINGLE 1
`define SYNC_ENC_BASE 2
`define DIV_LAST 6'h1f

`endif

//--- trig_enc_pkg.sv
/*
 * Types of the trigger and encoder unit: modes, states and the state record.
 * Assumes trig_enc_params.svh is on the include path.
 */
`include "trig_enc_params.svh"

package trig_enc_pkg;

	typedef enum logic [2:0] {
		ORG_NONE, ORG_DIFF, ORG_SINGLE, ORG_CMD, ORG_ENC_A, ORG_ENC_B, ORG_ENC_C
	} origin_t;

	typedef enum logic [1:0] {MARK_IGNORE, MARK_FIRST, MARK_EVERY} marker_t;

	typedef enum logic [1:0] {DEPTH_1, DEPTH_2, DEPTH_4} depth_t;

	typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		origin_t origin;
		logic target;
		logic kind;
		logic pol;
		logic htl;
		logic third_on;
		logic [31:0] per_trig;
		logic [31:0] win_lo;
		logic [31:0] win_hi;
		logic [31:0] spacing;
		logic [2:0][1:0] depth;
		logic [1:0][1:0] marker;
		logic [2:0][31:0] preset;
		logic [1:0][31:0] wrap;
		logic [2:0][31:0] cnt;
		logic [1:0] seen;
		logic [`SYNC_W-1:0] sync1;
		logic [`SYNC_W-1:0] sync2;
		logic [`SYNC_W-1:0] prev;
		logic lvl_prev;
		logic [31:0] remain;
		logic infinite;
		logic release_on;
		logic trig_out;
		logic clr_ts_pend;
		logic clr_mc_pend;
		logic clr_ts_out;
		logic clr_mc_out;
		div_state_t dstate;
		logic [5:0] dstep;
		logic [31:0] dorig;
		logic [31:0] dval;
		logic [31:0] drem;
		logic dnew;
		logic [31:0] dnext;
	} state_t;

endpackage

//--- trigger_and_encoder_unit.sv
/*
 * Trigger origin selection, value release and three quadrature position counters,
 * with an AHB-Lite register slave.
 * Assumes one 10 MHz clock, synchronous active-high reset, a single AHB-Lite master
 * doing whole-word single transfers, and a downstream value path that pulses
 * value_done_i once per value it puts out.
 */
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - triggers come from exactly one chosen origin, or none
// - command trigger fires only while command origin is selected
// - third counter origin fires only when third counter is on
// - acquisition target: trigger starts capture, averaging skips recent values
// - output target: trigger gates output, averaging uses recent values
// - after reset the target is acquisition triggering
// - edge or level kind matters only for the two pin origins
// - polarity high means rising or high-active, low means falling or low-active
// - each trigger releases n values, or unlimited; none stops triggering
// - encoder triggers only inside 32-bit lower and upper position limits
// - 32-bit spacing; spacing zero fires on every value inside the window
// - encoder triggers fire at whole multiples of spacing
// - each counter counts one, two or four steps per encoder period
// - counters a and b: marks ignored, preset at first mark, or every mark
// - counters a and b load their 32-bit preset on a mark or on command; counter c on command only
// - writing a preset clears that counter's first-mark detection
// - preset load command acts only when marker handling is ignore
// - first-mark clear command acts only when marker handling is ignore
// - counters a and b return to zero after passing their wrap limit
// - switching third counter on forces marker handling of a and b to ignore
// - single-ended input threshold family is selectable; sync input is differential
// - counter clear requests take effect at the next trigger edge
module trigger_and_encoder_unit
	import trig_enc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic sync_diff_i,
	input wire logic trig_single_i,
	input wire logic [2:0] enc_a_i,
	input wire logic [2:0] enc_b_i,
	input wire logic [2:0] enc_ref_i,
	input wire logic value_done_i,
	output logic trigger_pulse_o,
	output logic value_release_o,
	output logic averaging_recent_o,
	output logic threshold_htl_o,
	output logic timestamp_clear_o,
	output logic meas_count_clear_o
);

	state_t s;
	state_t next_s;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic take;
		logic [31:0] wd;
		logic [7:0] cmd;
		logic a, ap, b, bp, r, rp;
		logic ev, up, load, on;
		logic [1:0] mk;
		logic [31:0] lim;
		logic [2:0] upd;
		logic pin_org, pin, lvl, edge_ev, hit, trig_ev;
		logic [32:0] rem;
		logic [1:0] sel;
		logic sel_ok;
		take = 1'b0;
		wd = hwdata_i;
		cmd = 8'h00;
		a = 1'b0;
		ap = 1'b0;
		b = 1'b0;
		bp = 1'b0;
		r = 1'b0;
		rp = 1'b0;
		ev = 1'b0;
		up = 1'b0;
		load = 1'b0;
		on = 1'b0;
		mk = 2'h0;
		lim = 32'h0;
		upd = 3'h0;
		hit = 1'b0;
		rem = 33'h0;
		pin_org = 1'b0;
		pin = 1'b0;
		lvl = 1'b0;
		edge_ev = 1'b0;
		trig_ev = 1'b0;
		sel = 2'h0;
		sel_ok = 1'b0;
		next_s = s;

		// input synchronisers: first stage feeds only the second
		next_s.sync1 = {enc_ref_i[2], enc_b_i[2], enc_a_i[2], enc_ref_i[1], enc_b_i[1],
			enc_a_i[1], enc_ref_i[0], enc_b_i[0], enc_a_i[0], trig_single_i,
			sync_diff_i};
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;

		// ----------------------------------------
		// bus: address phase capture and register writes
		// ----------------------------------------
		// zero wait states: a write lands at the end of its data phase, so a read
		// whose address phase follows at once still sees the old value
		take = hsel_i && hready_i && htrans_i[1] && (hsize_i == `HSIZE_WORD);
		next_s.wr_pend = take && hwrite_i;
		next_s.wr_addr = haddr_i[7:0];
		if (s.wr_pend) begin
			case (s.wr_addr)
				`OFS_CTRL: begin
					next_s.origin = origin_t'(wd[`CTRL_ORIGIN_LSB +: 3]);
					next_s.target = wd[`CTRL_TARGET_BIT];
					next_s.kind = wd[`CTRL_KIND_BIT];
					next_s.pol = wd[`CTRL_POL_BIT];
					next_s.htl = wd[`CTRL_HTL_BIT];
					next_s.third_on = wd[`CTRL_THIRD_BIT];
					if (wd[`CTRL_THIRD_BIT]) begin
						next_s.marker = {MARK_IGNORE, MARK_IGNORE};
					end
				end
				`OFS_PER_TRIG: begin
					next_s.per_trig = wd;
					// a new count clears remain and infinite, unless value_done_i in the same cycle leaves remain one lower or a trigger in it reloads the old count
					next_s.remain = 32'h0;
					next_s.infinite = 1'b0;
				end
				`OFS_WIN_LO: next_s.win_lo = wd;
				`OFS_WIN_HI: next_s.win_hi = wd;
				`OFS_SPACING: next_s.spacing = wd;
				`OFS_DEPTH: next_s.depth = wd[5:0];
				`OFS_MARKER: begin
					if (!s.third_on) begin
						next_s.marker = wd[3:0];
					end
				end
				`OFS_PRESET_A: begin
					next_s.preset[0] = wd;
					next_s.seen[0] = 1'b0;
				end
				`OFS_PRESET_B: begin
					next_s.preset[1] = wd;
					next_s.seen[1] = 1'b0;
				end
				`OFS_PRESET_C: next_s.preset[2] = wd;
				`OFS_WRAP_A: next_s.wrap[0] = wd;
				`OFS_WRAP_B: next_s.wrap[1] = wd;
				`OFS_CMD: cmd = wd[7:0];
				default: ;
			endcase
		end

		// ----------------------------------------
		// position counters
		// ----------------------------------------
		for (int i = 0; i < 3; i++) begin
			a = s.sync2[`SYNC_ENC_BASE + 3 * i];
			ap = s.prev[`SYNC_ENC_BASE + 3 * i];
			b = s.sync2[`SYNC_ENC_BASE + 3 * i + 1];
			bp = s.prev[`SYNC_ENC_BASE + 3 * i + 1];
			r = s.sync2[`SYNC_ENC_BASE + 3 * i + 2];
			rp = s.prev[`SYNC_ENC_BASE + 3 * i + 2];
			case (depth_t'(s.depth[i]))
				DEPTH_1: begin
					ev = a && !ap;
					up = !b;
				end
				DEPTH_2: begin
					ev = a ^ ap;
					up = a ^ b;
				end
				default: begin
					ev = (a ^ ap) || (b ^ bp);
					up = (a ^ ap) ? (a ^ b) : !(a ^ b);
				end
			endcase
			on = (i < 2) || s.third_on;
			mk = MARK_IGNORE;
			lim = 32'hffff_ffff;
			// counter c has no marker input and runs over the full 32-bit range
			if (i < 2) begin
				lim = s.wrap[i[0]];
				if (!s.third_on) begin
					mk = s.marker[i[0]];
				end
			end
			load = cmd[`CMD_LOAD_LSB + i] && (mk == MARK_IGNORE);
			if (i < 2 && r && !rp) begin
				if (mk == MARK_EVERY || (mk == MARK_FIRST && !s.seen[i[0]])) begin
					load = 1'b1;
				end
				if (mk != MARK_IGNORE) begin
					next_s.seen[i[0]] = 1'b1;
				end
			end
			if (i < 2 && cmd[`CMD_MCLR_LSB + i] && mk == MARK_IGNORE) begin
				next_s.seen[i[0]] = 1'b0;
			end
			if (!on) begin
				ev = 1'b0;
				load = 1'b0;
			end
			// a load in the same cycle as a step wins; that step is lost
			if (load) begin
				next_s.cnt[i] = s.preset[i];
			end else if (ev && up) begin
				next_s.cnt[i] = (s.cnt[i] >= lim) ? 32'h0 : s.cnt[i] + 32'h1;
			end else if (ev) begin
				next_s.cnt[i] = (s.cnt[i] == 32'h0) ? lim : s.cnt[i] - 32'h1;
			end
			upd[i] = load || ev;
		end

		// ----------------------------------------
		// window and spacing check, serial remainder
		// ----------------------------------------
		// a 32-step remainder replaces a full divider; a counter moving faster than
		// one step per 33 cycles is checked at its latest value only
		sel = (s.origin == ORG_ENC_B) ? 2'h1 : (s.origin == ORG_ENC_C) ? 2'h2 : 2'h0;
		sel_ok = (s.origin == ORG_ENC_A) || (s.origin == ORG_ENC_B) ||
			(s.origin == ORG_ENC_C && s.third_on);
		if (sel_ok && upd[sel]) begin
			next_s.dnew = 1'b1;
			next_s.dnext = next_s.cnt[sel];
		end
		case (s.dstate)
			DIV_IDLE: begin
				if (s.dnew) begin
					next_s.dnew = sel_ok && upd[sel];
					next_s.dorig = s.dnext;
					next_s.dval = s.dnext;
					next_s.drem = 32'h0;
					next_s.dstep = 6'h0;
					next_s.dstate = DIV_RUN;
				end
			end
			DIV_RUN: begin
				rem = {s.drem, s.dval[31]};
				if (rem >= {1'b0, s.spacing}) begin
					rem = rem - {1'b0, s.spacing};
				end
				next_s.drem = rem[31:0];
				next_s.dval = {s.dval[30:0], 1'b0};
				next_s.dstep = s.dstep + 6'h1;
				if (s.dstep == `DIV_LAST) begin
					hit = (s.dorig >= s.win_lo) && (s.dorig <= s.win_hi) &&
						(s.spacing == 32'h0 || rem[31:0] == 32'h0);
					next_s.dstate = DIV_IDLE;
				end
			end
			default: next_s.dstate = DIV_IDLE;
		endcase
		if (!sel_ok) begin
			hit = 1'b0;
			next_s.dnew = 1'b0;
		end

		// ----------------------------------------
		// trigger origin and release
		// ----------------------------------------
		// lvl_prev tracks the selected pin every cycle, so a change of origin or
		// polarity fires only if the new level is active and the old one was not
		pin_org = (s.origin == ORG_DIFF) || (s.origin == ORG_SINGLE);
		pin = (s.origin == ORG_DIFF) ? s.sync2[`SYNC_DIFF] : s.sync2[`SYNC_SINGLE];
		lvl = s.pol ? pin : !pin;
		next_s.lvl_prev = lvl;
		edge_ev = pin_org && lvl && !s.lvl_prev;
		trig_ev = edge_ev ||
			(cmd[`CMD_TRIGGER_BIT] && s.origin == ORG_CMD) ||
			hit;
		if (s.per_trig == `PER_TRIG_NONE) begin
			trig_ev = 1'b0;
		end
		next_s.trig_out = trig_ev;
		if (s.remain != 32'h0 && value_done_i) begin
			next_s.remain = s.remain - 32'h1;
		end
		if (trig_ev) begin
			if (s.per_trig == `PER_TRIG_INFINITE) begin
				next_s.infinite = 1'b1;
			end else begin
				next_s.remain = s.per_trig;
			end
		end
		if (pin_org && s.kind) begin
			// level kind: release follows the active level
			next_s.release_on = lvl && (s.per_trig != `PER_TRIG_NONE);
		end else begin
			next_s.release_on = next_s.infinite || (next_s.remain != 32'h0);
		end

		// clear requests wait for the next trigger; a new request wins over release
		next_s.clr_ts_out = s.clr_ts_pend && trig_ev;
		next_s.clr_mc_out = s.clr_mc_pend && trig_ev;
		next_s.clr_ts_pend = (s.clr_ts_pend && !trig_ev) || cmd[`CMD_CLR_TS_BIT];
		next_s.clr_mc_pend = (s.clr_mc_pend && !trig_ev) || cmd[`CMD_CLR_MC_BIT];

		// ----------------------------------------
		// bus: read data captured in the address phase
		// ----------------------------------------
		next_s.rdata = 32'h0;
		if (take && !hwrite_i) begin
			case (haddr_i[7:0])
				`OFS_CTRL: next_s.rdata = {24'h0, s.third_on, s.htl, s.pol, s.kind,
					s.target, s.origin};
				`OFS_PER_TRIG: next_s.rdata = s.per_trig;
				`OFS_WIN_LO: next_s.rdata = s.win_lo;
				`OFS_WIN_HI: next_s.rdata = s.win_hi;
				`OFS_SPACING: next_s.rdata = s.spacing;
				`OFS_DEPTH: next_s.rdata = {26'h0, s.depth};
				`OFS_MARKER: next_s.rdata = {28'h0, s.marker};
				`OFS_PRESET_A: next_s.rdata = s.preset[0];
				`OFS_PRESET_B: next_s.rdata = s.preset[1];
				`OFS_PRESET_C: next_s.rdata = s.preset[2];
				`OFS_WRAP_A: next_s.rdata = s.wrap[0];
				`OFS_WRAP_B: next_s.rdata = s.wrap[1];
				`OFS_STATUS: next_s.rdata = {27'h0, s.clr_mc_pend, s.clr_ts_pend,
					s.seen, s.release_on};
				`OFS_CNT_A: next_s.rdata = s.cnt[0];
				`OFS_CNT_B: next_s.rdata = s.cnt[1];
				`OFS_CNT_C: next_s.rdata = s.cnt[2];
				`OFS_REMAIN: next_s.rdata = s.remain;
				default: next_s.rdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// only the count per trigger and the wrap limits leave reset non-zero
			s <= '0;
			s.per_trig <= `PER_TRIG_RESET;
			s.wrap <= {`WRAP_RESET, `WRAP_RESET};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata_o = s.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign trigger_pulse_o = s.trig_out;
	assign value_release_o = s.release_on;
	assign averaging_recent_o = s.target;
	assign threshold_htl_o = s.htl;
	assign timestamp_clear_o = s.clr_ts_out;
	assign meas_count_clear_o = s.clr_mc_out;

endmodule // trigger_and_encoder_unit

`default_nettype wire

//--- enc_src_model.sv
/*
 * Far-side model: quadrature encoder and reference mark for counter a.
 * Assumes step_i is a one-cycle request in the clk_i domain; counters b and c stay idle.
 */
`timescale 1ns/1ps
`default_nettype none

module enc_src_model (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic ref_i,
	output logic [2:0] enc_a_o,
	output logic [2:0] enc_b_o,
	output logic [2:0] enc_ref_o
);
	// ----------------------------------------
	// quadrature phase
	// ----------------------------------------
	logic [1:0] phase = 2'h0;
	// forward only: a leads b, so every full period counts upward
	always_ff @(posedge clk_i) begin
		if (step_i)
			phase <= phase + 2'h1;
	end
	assign enc_a_o = {2'b00, phase == 2'h1 || phase == 2'h2};
	assign enc_b_o = {2'b00, phase[1]};
	assign enc_ref_o = {2'b00, ref_i};
endmodule // enc_src_model

`default_nettype wire

//--- trigger_and_encoder_unit_chk.sv
/*
 * Port checker of the trigger unit, bound to its top module.
 * Assumes whole-word single transfers; it mirrors control and count writes.
 */
`timescale 1ns/1ps
`default_nettype none

module trig_enc_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic trig_single_i,
	input wire logic trigger_pulse_o,
	input wire logic value_release_o,
	input wire logic averaging_recent_o,
	input wire logic threshold_htl_o,
	input wire logic timestamp_clear_o,
	input wire logic meas_count_clear_o
);
	// ----------------------------------------
	// mirror of written settings
	// ----------------------------------------
	logic dw;
	logic [7:0] da;
	logic [7:0] ctl;
	logic [31:0] npt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dw <= 1'b0;
			ctl <= 8'h00;
			npt <= 32'hffff_ffff;
		end else begin
			dw <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
			if (dw && da == 8'h00)
				ctl <= hwdata_i[7:0];
			if (dw && da == 8'h04)
				npt <= hwdata_i;
		end
		da <= haddr_i[7:0];
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence cmd_wr;
		dw && da == 8'h30 && hwdata_i[0];
	endsequence
	sequence pin_up;
		$rose(trig_single_i) ##0 ctl[2:0] == 3'h2 && ctl[5:4] == 2'b10 && npt != 32'h0;
	endsequence

	AST_CMD_FIRE: assert property (cmd_wr ##0 ctl[2:0] == 3'h3 && npt != 32'h0
		|=> trigger_pulse_o)
		else $error("command trigger gave no pulse");
	AST_NO_ORIGIN: assert property (ctl[2:0] == 3'h0 && $past(ctl[2:0]) == 3'h0
		|-> !trigger_pulse_o)
		else $error("pulse with no origin");
	AST_NONE_STOPS: assert property (npt == 32'h0 && $past(npt) == 32'h0
		|-> !trigger_pulse_o)
		else $error("pulse while count is none");
	AST_ONE_CYCLE: assert property (trigger_pulse_o |=> !trigger_pulse_o)
		else $error("trigger pulse longer than one cycle");
	AST_REL_RISE: assert property ($rose(value_release_o) |-> trigger_pulse_o)
		else $error("release rose without trigger");
	AST_TARGET: assert property (ctl[3] == $past(ctl[3]) && ctl[3] == $past(ctl[3], 2)
		|-> averaging_recent_o == ctl[3])
		else $error("averaging mode differs from target");
	AST_HTL: assert property (ctl[6] == $past(ctl[6]) && ctl[6] == $past(ctl[6], 2)
		|-> threshold_htl_o == ctl[6])
		else $error("threshold family differs from setting");
	AST_TS_CLR: assert property (timestamp_clear_o |-> trigger_pulse_o)
		else $error("timestamp clear without trigger");
	AST_MC_CLR: assert property (meas_count_clear_o |-> trigger_pulse_o)
		else $error("count clear without trigger");
	AST_PIN_EDGE: assert property (pin_up |-> ##[2:6] trigger_pulse_o)
		else $error("rising pin edge gave no pulse");
endmodule // trig_enc_chk

bind trigger_and_encoder_unit trig_enc_chk trig_enc_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .trig_single_i(trig_single_i),
	.trigger_pulse_o(trigger_pulse_o), .value_release_o(value_release_o),
	.averaging_recent_o(averaging_recent_o), .threshold_htl_o(threshold_htl_o),
	.timestamp_clear_o(timestamp_clear_o), .meas_count_clear_o(meas_count_clear_o));

`default_nettype wire

//--- trigger_and_encoder_unit_tb.sv
/*
 * Self-checking bench: register tasks over the bus, pin and encoder traffic.
 * Assumes the unit, its checker and the encoder model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "trig_enc_params.svh"

module trigger_and_encoder_unit_tb;
	// ----------------------------------------
	// stimulus and bus tasks
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic sync_diff_i = 1'b0;
	logic trig_single_i = 1'b0;
	logic value_done_i = 1'b0;
	logic step = 1'b0;
	logic ref_mark = 1'b0;
	logic [31:0] hrdata_o, rd;
	logic hreadyout_o, hresp_o, trigger_pulse_o, value_release_o;
	logic averaging_recent_o, threshold_htl_o, timestamp_clear_o, meas_count_clear_o;
	logic [2:0] enc_a, enc_b, enc_ref;
	int fail_count = 0;
	int samples_checked = 0;
	int pulses = 0;
	int clears = 0;
	int mclears = 0;
	int p;

	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (trigger_pulse_o === 1'b1)
			pulses <= pulses + 1;
		if (timestamp_clear_o === 1'b1)
			clears <= clears + 1;
		if (meas_count_clear_o === 1'b1)
			mclears <= mclears + 1;
	end

	trigger_and_encoder_unit trigger_and_encoder_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(`HSIZE_WORD), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.sync_diff_i(sync_diff_i), .trig_single_i(trig_single_i), .enc_a_i(enc_a),
		.enc_b_i(enc_b), .enc_ref_i(enc_ref), .value_done_i(value_done_i),
		.trigger_pulse_o(trigger_pulse_o), .value_release_o(value_release_o),
		.averaging_recent_o(averaging_recent_o), .threshold_htl_o(threshold_htl_o),
		.timestamp_clear_o(timestamp_clear_o), .meas_count_clear_o(meas_count_clear_o));
	enc_src_model enc_src_model_inst (.clk_i(clk_i), .step_i(step), .ref_i(ref_mark),
		.enc_a_o(enc_a), .enc_b_o(enc_b), .enc_ref_o(enc_ref));

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// read data is taken at the edge ending the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask

	task automatic steps(input int n, input int gap);
		repeat (n) begin
			@(posedge clk_i);
			step <= 1'b1;
			@(posedge clk_i);
			step <= 1'b0;
			idle(gap);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(`OFS_CTRL, 32'h0, "ctrl");
		rchk(`OFS_PER_TRIG, `PER_TRIG_RESET, "per_trig");
		rchk(`OFS_WRAP_A, `WRAP_RESET, "wrap_a");
		rchk(8'h80, 32'h0, "unmapped");
		chk("bus_status", 32'({hreadyout_o, hresp_o}), 32'h2);
		wr(`OFS_CMD, 32'h1);
		idle(4);
		chk("no_origin", 32'(pulses), 32'h0);
		wr(`OFS_CTRL, 32'h3);
		wr(`OFS_PER_TRIG, 32'h2);
		wr(`OFS_CMD, 32'h1);
		idle(3);
		chk("cmd_pulse", 32'(pulses), 32'h1);
		chk("release", 32'(value_release_o), 32'h1);
		repeat (2) begin
			@(posedge clk_i);
			value_done_i <= 1'b1;
			@(posedge clk_i);
			value_done_i <= 1'b0;
		end
		idle(2);
		chk("released", 32'(value_release_o), 32'h0);
		wr(`OFS_PER_TRIG, `PER_TRIG_NONE);
		wr(`OFS_CMD, 32'h1);
		idle(3);
		chk("none_count", 32'(pulses), 32'h1);
		wr(`OFS_PER_TRIG, `PER_TRIG_INFINITE);
		// both pins move together; each pin origin and polarity must fire once on the active edge and not on the return
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CTRL, 32'h0);
			sync_diff_i <= ~i[1];
			trig_single_i <= ~i[1];
			wr(`OFS_CTRL, {26'h0, i[1], 2'b00, i[0] ? 3'h1 : 3'h2});
			p = pulses;
			sync_diff_i <= i[1];
			trig_single_i <= i[1];
			idle(8);
			chk("pin_edge", 32'(pulses - p), 32'h1);
			sync_diff_i <= ~i[1];
			trig_single_i <= ~i[1];
			idle(8);
			chk("pin_back", 32'(pulses - p), 32'h1);
		end
		wr(`OFS_CTRL, 32'h22);
		wr(`OFS_CMD, 32'hc0);
		idle(4);
		chk("clr_wait", 32'(clears), 32'h0);
		chk("mclr_wait", 32'(mclears), 32'h0);
		trig_single_i <= 1'b1;
		idle(8);
		chk("clr_edge", 32'(clears), 32'h1);
		chk("mclr_edge", 32'(mclears), 32'h1);
		trig_single_i <= 1'b0;
		wr(`OFS_CTRL, 32'h48);
		idle(3);
		chk("avg_recent", 32'(averaging_recent_o), 32'h1);
		chk("htl", 32'(threshold_htl_o), 32'h1);
		wr(`OFS_CTRL, 32'h0);
		idle(3);
		chk("avg_skip", 32'(averaging_recent_o), 32'h0);
		wr(`OFS_PRESET_A, 32'h100);
		wr(`OFS_CMD, 32'h2);
		rchk(`OFS_CNT_A, 32'h100, "load");
		wr(`OFS_MARKER, 32'h1);
		wr(`OFS_PRESET_A, 32'h200);
		wr(`OFS_CMD, 32'h2);
		rchk(`OFS_CNT_A, 32'h100, "load_blocked");
		ref_mark <= 1'b1;
		idle(6);
		ref_mark <= 1'b0;
		idle(6);
		rchk(`OFS_CNT_A, 32'h200, "mark_load");
		wr(`OFS_CMD, 32'h10);
		rchk(`OFS_STATUS, 32'h3, "seen_kept");
		wr(`OFS_PRESET_A, 32'h0);
		rchk(`OFS_STATUS, 32'h1, "seen_clear");
		wr(`OFS_MARKER, 32'h5);
		wr(`OFS_CTRL, 32'h80);
		rchk(`OFS_MARKER, 32'h0, "marker_forced");
		wr(`OFS_WRAP_A, 32'h2);
		wr(`OFS_CMD, 32'h2);
		steps(8, 8);
		rchk(`OFS_CNT_A, 32'h2, "x1_count");
		steps(4, 8);
		rchk(`OFS_CNT_A, 32'h0, "wrapped");
		wr(`OFS_WRAP_A, `WRAP_RESET);
		wr(`OFS_DEPTH, 32'h2);
		steps(4, 8);
		rchk(`OFS_CNT_A, 32'h4, "x4_count");
		wr(`OFS_DEPTH, 32'h1);
		steps(4, 8);
		rchk(`OFS_CNT_A, 32'h6, "x2_count");
		wr(`OFS_DEPTH, 32'h2);
		wr(`OFS_WIN_LO, 32'h5);
		wr(`OFS_WIN_HI, 32'h23);
		wr(`OFS_SPACING, 32'ha);
		wr(`OFS_CTRL, 32'h84);
		wr(`OFS_PRESET_A, 32'h8);
		wr(`OFS_CMD, 32'h2);
		idle(40);
		p = pulses;
		steps(27, 48);
		chk("enc_multiples", 32'(pulses - p), 32'h3);
		steps(10, 48);
		chk("enc_window", 32'(pulses - p), 32'h3);
		wr(`OFS_CTRL, 32'h86);
		wr(`OFS_PRESET_C, 32'h14);
		p = pulses;
		wr(`OFS_CMD, 32'h8);
		idle(45);
		chk("enc_c_on", 32'(pulses - p), 32'h1);
		wr(`OFS_CTRL, 32'h6);
		wr(`OFS_CMD, 32'h8);
		idle(45);
		chk("enc_c_off", 32'(pulses - p), 32'h1);
		wr(`OFS_CTRL, 32'h86);
		wr(`OFS_SPACING, 32'h0);
		wr(`OFS_PRESET_C, 32'h7);
		wr(`OFS_CMD, 32'h8);
		idle(45);
		chk("spacing_zero", 32'(pulses - p), 32'h2);
		wr(`OFS_CTRL, 32'h32);
		idle(3);
		chk("level_idle", 32'(value_release_o), 32'h0);
		trig_single_i <= 1'b1;
		idle(6);
		chk("level_on", 32'(value_release_o), 32'h1);
		trig_single_i <= 1'b0;
		idle(6);
		chk("level_off", 32'(value_release_o), 32'h0);
		conclude();
	end
endmodule // trigger_and_encoder_unit_tb

`default_nettype wire
